/* mct_regs.svh */
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH
// Contract
// - Fast clock divided by 1, 2, 4 or 8.
// - Cycle period equals 12-bit count times reference period.
// - Cycle times discharge first, then recharges.
// - Period expiry during discharge abandons and flags time-out.
// - Reference select: 0 fast clock, 1 slow clock.
// - Pulsed mode runs the oscillator only while measuring; the code does so only with slow reference and single conversion.
// - Full bridge is two halves in alternating cycles.
// - Power modes: off, on, warm 640 or 1280 us.
// - One measurement is eight cycles per half.

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MCT_ADDR_W      6
`define MCT_CFG1_IDX    6'h01
`define MCT_CFG1_ADDR   (`MCT_CFG1_IDX * 6'h04)
`define MCT_CTRL_ADDR   6'h20
`define MCT_CMD_ADDR    6'h24
`define MCT_STAT_ADDR   6'h28
`define MCT_DTIME_ADDR  6'h2c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MCT_CYC_LSB     12
`define MCT_CYC_MSB     23
`define MCT_CFG1_RST    24'h0e8001
`define MCT_CTRL_RST    7'h08
`define MCT_CMD_START   0
`define MCT_CMD_STOP    1
`define MCT_RESP_OKAY   2'h0
`define MCT_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCT_MCLK_KHZ    10000
`define MCT_WARM_SHORT_US 640
`define MCT_WARM_LONG_US  1280
`define MCT_WARM_SHORT_CYC ((`MCT_WARM_SHORT_US*`MCT_MCLK_KHZ+999)/1000)
`define MCT_WARM_LONG_CYC  ((`MCT_WARM_LONG_US*`MCT_MCLK_KHZ+999)/1000)
`define MCT_CYC_PER_HALF 4'h8
`endif

/* mct_pkg.sv */
package mct_pkg;
    // Measurement sequencer phases.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WARM,
        PH_DIS,
        PH_REC
    } mct_phase_t;

    // Control register layout, divide select in the low bits.
    typedef struct packed {
        logic       full_bridge;
        logic       single_conversion_select;
        logic [1:0] fast_osc_power_mode;
        logic       cycle_reference_select;
        logic [1:0] fast_clock_divide_select;
    } mct_ctrl_t;

    // Settings handed to the reference generator.
    typedef struct packed {
        logic [1:0] fast_clock_divide_select;
        logic       cycle_reference_select;
    } mct_refcfg_t;

    // Byte-lane merge for AXI write strobes.
    function automatic logic [31:0] mct_merge(logic [31:0] o,
                                              logic [31:0] d,
                                              logic [3:0]  b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : mct_merge
endpackage : mct_pkg

/* mct_refgen.sv */
module mct_refgen (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 fast_reference_clock,
    input  wire logic                 slow_osc_input,
    input  wire mct_pkg::mct_refcfg_t cfg,
    output logic                      ref_tick
);
    import mct_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] fsync;   // Fast pin synchroniser.
        logic [1:0] ssync;   // Slow pin synchroniser.
        logic       flast;   // Previous synchronised fast level.
        logic       slast;   // Previous synchronised slow level.
        logic [2:0] divcnt;  // Fast edge counter for the divider.
        logic       tick;    // One-cycle reference tick.
    } mct_ref_state_t;

    mct_ref_state_t s, n;
    logic fedge, sedge;
    logic [2:0] mask;

    // Edges and divider mask. Pins are sampled by mclk, so the fast
    // reference must stay well below half the mclk rate.
    always_comb begin
        n      = s;
        fedge  = s.fsync[1] & ~s.flast;
        sedge  = s.ssync[1] & ~s.slast;
        mask   = 3'((4'h1 << cfg.fast_clock_divide_select) - 4'h1);
        n.fsync = {s.fsync[0], fast_reference_clock};
        n.ssync = {s.ssync[0], slow_osc_input};
        n.flast = s.fsync[1];
        n.slast = s.ssync[1];
        if (fedge) begin
            n.divcnt = s.divcnt + 3'h1;
        end
        // Select the time base of the cycle period.
        if (cfg.cycle_reference_select) begin
            n.tick = sedge;
        end else begin
            n.tick = fedge && ((s.divcnt & mask) == mask);
        end
    end

    // Register the whole state.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign ref_tick = s.tick;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    undivided_tick_a: assert property (
        !cfg.cycle_reference_select && cfg.fast_clock_divide_select == 2'h0
        && fedge |=> s.tick)
        else $error("undivided fast edge gave no tick");
    slow_tick_a: assert property (
        cfg.cycle_reference_select |=> s.tick == $past(sedge))
        else $error("slow reference tick mismatch");
endmodule : mct_refgen

/* mct_timer.sv */
// Added by the designer: the AXI4-Lite slave port.
`include "mct_regs.svh"
module mct_timer #(
    parameter int WARM_SHORT_CYC = `MCT_WARM_SHORT_CYC,
    parameter int WARM_LONG_CYC  = `MCT_WARM_LONG_CYC
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   fast_reference_clock,
    input  wire logic                   slow_osc_input,
    input  wire logic                   comparator_trip,
    input  wire logic [`MCT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`MCT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        fast_osc_enable,
    output logic                        discharge_active,
    output logic                        bridge_half_select,
    output logic                        measure_done,
    output logic                        time_out_flag
);
    import mct_pkg::*;

    // The warm-up counter is 14 bits wide.
    if (WARM_SHORT_CYC < 1 || WARM_LONG_CYC < 1
        || WARM_SHORT_CYC > 16384 || WARM_LONG_CYC > 16384) begin : g_chk
        $error("warm-up counts out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        mct_phase_t             phase;    // Sequencer phase.
        logic [23:0]            cfg1;     // Averaging and cycle config.
        mct_ctrl_t              ctrl;     // Clock and mode control.
        logic [13:0]            warm;     // Oscillator settle counter.
        logic [11:0]            refcnt;   // Reference ticks this cycle.
        logic [15:0]            dcnt;     // Discharge time in mclk.
        logic [15:0]            dtime;    // Last discharge time.
        logic [3:0]             cyc;      // Cycle within measurement.
        logic                   half;     // Half bridge in use.
        logic                   timeout;  // Sticky time-out flag.
        logic                   osc_on;   // Oscillator enable.
        logic                   discharge;// Discharge phase output.
        logic                   done;     // Measurement end pulse.
        logic [1:0]             tsync;    // Comparator synchroniser.
        logic                   aw_held;  // Write address captured.
        logic                   w_held;   // Write data captured.
        logic [`MCT_ADDR_W-1:0] waddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } mct_state_t;

    mct_state_t s, n;
    logic        ref_tick;   // Reference tick from the generator.
    logic        trip;       // Synchronised comparator crossing.
    logic        expire;     // Cycle period ends with this tick.
    logic        start_cmd;
    logic        stop_cmd;
    logic [3:0]  last_cyc;
    logic [13:0] warm_lim;
    logic [`MCT_ADDR_W-1:0] wa, ra;

    // ----------------------------------------------------------------
    // Reference clock path
    // ----------------------------------------------------------------
    mct_refgen u_refgen (
        .mclk                 (mclk),
        .reset_n              (reset_n),
        .fast_reference_clock (fast_reference_clock),
        .slow_osc_input       (slow_osc_input),
        .cfg                  ('{s.ctrl.fast_clock_divide_select,
                                 s.ctrl.cycle_reference_select}),
        .ref_tick             (ref_tick)
    );

    // Next-state logic: bus slave first, then the sequencer, so that a
    // time-out in the same cycle as a status read still sets the flag.
    always_comb begin
        n         = s;
        n.done    = 1'b0;
        start_cmd = 1'b0;
        stop_cmd  = 1'b0;
        n.tsync   = {s.tsync[0], comparator_trip};
        trip      = s.tsync[1];
        expire    = ref_tick && ({1'b0, s.refcnt} + 13'h1
                    >= {1'b0, s.cfg1[`MCT_CYC_MSB:`MCT_CYC_LSB]});
        last_cyc  = s.ctrl.full_bridge ? 4'((`MCT_CYC_PER_HALF << 1) - 4'h1)
                                       : `MCT_CYC_PER_HALF - 4'h1;
        warm_lim  = (s.ctrl.fast_osc_power_mode == 2'h3)
                    ? 14'(WARM_LONG_CYC - 1) : 14'(WARM_SHORT_CYC - 1);
        wa        = {s.waddr[`MCT_ADDR_W-1:2], 2'h0};
        ra        = {s_axi_araddr[`MCT_ADDR_W-1:2], 2'h0};

        // Write channels are taken independently, in either order.
        if (s_axi_awvalid && s.awready) begin
            n.aw_held = 1'b1;
            n.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_held = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `MCT_RESP_OKAY;
            if (wa == `MCT_CFG1_ADDR) begin
                n.cfg1 = 24'(mct_merge({8'h0, s.cfg1}, s.wdata, s.wstrb));
            end else if (wa == `MCT_CTRL_ADDR) begin
                n.ctrl = 7'(mct_merge({25'h0, s.ctrl}, s.wdata, s.wstrb));
            end else if (wa == `MCT_CMD_ADDR) begin
                start_cmd = s.wstrb[0] && s.wdata[`MCT_CMD_START];
                stop_cmd  = s.wstrb[0] && s.wdata[`MCT_CMD_STOP];
            end else if (wa != `MCT_STAT_ADDR && wa != `MCT_DTIME_ADDR) begin
                n.bresp = `MCT_RESP_SLVERR;
            end
        end

        // Read channel; reading status clears the time-out flag.
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = `MCT_RESP_OKAY;
            n.rdata  = 32'h0;
            if (ra == `MCT_CFG1_ADDR) begin
                n.rdata = {8'h0, s.cfg1};
            end else if (ra == `MCT_CTRL_ADDR) begin
                n.rdata = {25'h0, s.ctrl};
            end else if (ra == `MCT_STAT_ADDR) begin
                n.rdata   = {25'h0, s.half, s.cyc, s.phase != PH_IDLE,
                             s.timeout};
                n.timeout = 1'b0;
            end else if (ra == `MCT_DTIME_ADDR) begin
                n.rdata = {16'h0, s.dtime};
            end else if (ra != `MCT_CMD_ADDR) begin
                n.rresp = `MCT_RESP_SLVERR;
            end
        end

        // Measurement sequencer.
        unique case (s.phase)
            PH_IDLE: begin
                if (start_cmd) begin
                    n.cyc  = 4'h0;
                    n.half = 1'b0;
                    if (s.ctrl.fast_osc_power_mode[1] && !s.osc_on) begin
                        n.warm  = 14'h0;
                        n.phase = PH_WARM;
                    end else begin
                        n.phase = PH_DIS;
                    end
                end
            end
            PH_WARM: begin
                // Let the oscillator settle before the first cycle.
                n.warm = s.warm + 14'h1;
                if (s.warm >= warm_lim) begin
                    n.phase = PH_DIS;
                end
            end
            PH_DIS: begin
                n.dcnt = (s.dcnt == 16'hffff) ? s.dcnt : s.dcnt + 16'h1;
                if (ref_tick) begin
                    n.refcnt = s.refcnt + 12'h1;
                end
                if (trip) begin
                    // Threshold crossed: keep the time, start recharge.
                    n.dtime = s.dcnt;
                    n.phase = PH_REC;
                end else if (expire) begin
                    // Discharge outlasted the cycle; give up the result.
                    n.timeout = 1'b1;
                    n.phase   = PH_IDLE;
                end
            end
            PH_REC: begin
                if (ref_tick) begin
                    n.refcnt = s.refcnt + 12'h1;
                end
                if (expire) begin
                    if (s.cyc == last_cyc) begin
                        n.done = 1'b1;
                        n.cyc  = 4'h0;
                        n.half = 1'b0;
                        n.phase = s.ctrl.single_conversion_select
                                  ? PH_IDLE : PH_DIS;
                    end else begin
                        n.cyc   = s.cyc + 4'h1;
                        n.half  = s.ctrl.full_bridge ? ~s.half : 1'b0;
                        n.phase = PH_DIS;
                    end
                end
            end
        endcase
        if (stop_cmd) begin
            n.phase = PH_IDLE;
        end
        // A fresh cycle starts with the capacitor discharging.
        if (n.phase == PH_DIS && s.phase != PH_DIS) begin
            n.refcnt = 12'h0;
            n.dcnt   = 16'h0;
        end
        n.discharge = (n.phase == PH_DIS);

        // Oscillator power: pulsed only with slow base and single shot.
        unique case (n.ctrl.fast_osc_power_mode)
            2'h0: n.osc_on = 1'b0;
            2'h1: n.osc_on = 1'b1;
            default: n.osc_on = (n.ctrl.cycle_reference_select
                                 && n.ctrl.single_conversion_select)
                                ? (n.phase != PH_IDLE) : 1'b1;
        endcase

        // Ready outputs follow the held, bvalid and rvalid flags so that each stays a flop.
        n.awready = !n.aw_held && !n.bvalid;
        n.wready  = !n.w_held && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // Register the whole state; reset takes constants only.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s       <= '0;
            s.phase <= PH_IDLE;
            s.cfg1  <= `MCT_CFG1_RST;
            s.ctrl  <= `MCT_CTRL_RST;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready      = s.awready;
    assign s_axi_wready       = s.wready;
    assign s_axi_bvalid       = s.bvalid;
    assign s_axi_bresp        = s.bresp;
    assign s_axi_arready      = s.arready;
    assign s_axi_rvalid       = s.rvalid;
    assign s_axi_rdata        = s.rdata;
    assign s_axi_rresp        = s.rresp;
    assign fast_osc_enable    = s.osc_on;
    assign discharge_active   = s.discharge;
    assign bridge_half_select = s.half;
    assign measure_done       = s.done;
    assign time_out_flag      = s.timeout;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence dis_expire_s;
        s.phase == PH_DIS && !trip && expire && !stop_cmd;
    endsequence
    sequence rec_expire_s;
        s.phase == PH_REC && expire && !stop_cmd;
    endsequence

    timeout_set_a: assert property (dis_expire_s |=>
        s.timeout && s.phase == PH_IDLE && !s.discharge)
        else $error("expiry in discharge gave no time-out");
    trip_recharge_a: assert property (
        s.phase == PH_DIS && trip && !stop_cmd |=>
        s.phase == PH_REC && !s.discharge && s.dtime == $past(s.dcnt))
        else $error("comparator trip did not start recharge");
    next_cycle_a: assert property (
        rec_expire_s and (s.cyc != last_cyc) |=>
        s.phase == PH_DIS && s.discharge && s.refcnt == 12'h0)
        else $error("next cycle did not start with discharge");
    meas_done_a: assert property (
        rec_expire_s and (!s.ctrl.full_bridge && s.cyc == 4'h7) |=>
        s.done && s.cyc == 4'h0)
        else $error("half bridge did not end after eight cycles");
    half_toggle_a: assert property (
        rec_expire_s and (s.ctrl.full_bridge && s.cyc != 4'hf) |=>
        s.half != $past(s.half))
        else $error("full bridge half did not alternate");
    ref_count_a: assert property (
        s.phase == PH_DIS && ref_tick && !trip && !expire && !stop_cmd |=>
        s.refcnt == $past(s.refcnt) + 12'h1)
        else $error("reference ticks not counted");
    osc_off_a: assert property (
        s.osc_on |-> s.ctrl.fast_osc_power_mode != 2'h0)
        else $error("oscillator on in mode zero");
    warm_end_a: assert property (
        s.phase == PH_WARM && s.warm >= warm_lim && !stop_cmd |=>
        s.phase == PH_DIS)
        else $error("warm-up did not end on time");
    osc_pulse_a: assert property (
        s.phase == PH_IDLE && s.ctrl.fast_osc_power_mode[1]
        && s.ctrl.cycle_reference_select
        && s.ctrl.single_conversion_select |-> !s.osc_on)
        else $error("pulsed oscillator left running when idle");
    timeout_hold_a: assert property (
        s.timeout && !(s_axi_arvalid && s.arready) |=> s.timeout)
        else $error("time-out flag lost before status read");
    bresp_hold_a: assert property (
        s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
        else $error("write response dropped before bready");
endmodule : mct_timer

/* tb.sv */
`include "mct_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mct_pkg::*;

    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    logic        mclk, reset_n, fast_clk, slow_clk, trip, trip_en;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        osc_en, dis_act, half, done, tout;
    logic [4:0]  div_cnt;
    int          num_errors = 0;
    int          n_compared = 0;

    // Warm-up counts are shortened so the pulsed modes finish quickly.
    mct_timer #(.WARM_SHORT_CYC(8), .WARM_LONG_CYC(16)) u_dut (
        .mclk(mclk), .reset_n(reset_n), .fast_reference_clock(fast_clk),
        .slow_osc_input(slow_clk), .comparator_trip(trip),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fast_osc_enable(osc_en), .discharge_active(dis_act),
        .bridge_half_select(half), .measure_done(done),
        .time_out_flag(tout));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Fast pin has a 4-cycle period, slow pin 32; both well under mclk/2.
    always @(posedge mclk) begin
        div_cnt  <= div_cnt + 5'h01;
        fast_clk <= div_cnt[1];
        slow_clk <= div_cnt[4];
        trip     <= trip_en & dis_act;
    end

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    // Waits have no limit of their own; the watchdog ends a hang.
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", `MCT_RESP_OKAY, bresp);
    endtask : axi_wr

    task automatic axi_rd(input logic [5:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Measured spans may be off by one reference period and sync delay.
    task automatic chk_near(input string nm, input int e, input int g,
                            input int tol);
        n_compared++;
        if (g < e - tol || g > e + tol) begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_near

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        chk("osc_on_mode1", 1, osc_en);
        axi_rd(`MCT_CFG1_ADDR, d, r);
        chk("cfg1_reset", 32'h000e8001, d);
        axi_rd(`MCT_CTRL_ADDR, d, r);
        chk("ctrl_reset", 32'h8, d);
        axi_rd(6'h10, d, r);
        chk("unmapped_resp", `MCT_RESP_SLVERR, r);
        axi_wr(`MCT_CTRL_ADDR, 32'h0);
        repeat (3) @(posedge mclk);
        chk("osc_off_mode0", 0, osc_en);
    endtask : t_reset

    // No trip: the period runs out during discharge.
    task automatic t_timeout(input logic [6:0] c, input int cnt, int per);
        logic [31:0] d;
        logic [1:0]  r;
        int          len;
        axi_wr(`MCT_CFG1_ADDR, {8'h00, cnt[11:0], 12'h001});
        axi_wr(`MCT_CTRL_ADDR, {25'h0, c});
        axi_wr(`MCT_CMD_ADDR, 32'h1);
        len = 0;
        while (!dis_act && len < 5000) begin
            @(posedge mclk);
            len++;
        end
        len = 0;
        while (dis_act && len < 5000) begin
            @(posedge mclk);
            len++;
        end
        chk_near("timeout_len", cnt * per, len, per + 6);
        repeat (3) @(posedge mclk);
        chk("timeout_flag", 1, tout);
        axi_rd(`MCT_STAT_ADDR, d, r);
        chk("stat_first", 1, d[0]);
        axi_rd(`MCT_STAT_ADDR, d, r);
        chk("stat_second", 0, d[0]);
        chk("flag_cleared", 0, tout);
    endtask : t_timeout

    // Trip early: count cycles and halves up to the done pulse.
    task automatic t_meas(input logic full);
        logic [31:0] d;
        logic [1:0]  r;
        int          cyc, hi, n, t0, t1;
        logic        was;
        {cyc, hi, n, t0, t1, was} = '0;
        trip_en <= 1'b1;
        axi_wr(`MCT_CFG1_ADDR, {8'h00, 12'd20, 12'h001});
        axi_wr(`MCT_CTRL_ADDR, {25'h0, full, 6'b101000});
        axi_wr(`MCT_CMD_ADDR, 32'h1);
        while (!done && n < 20000) begin
            @(posedge mclk);
            n++;
            if (dis_act && !was) begin
                cyc++;
                if (half === 1'b1) hi++;
                // Skip the first cycle: its start lands anywhere
                // between two reference ticks, so its length varies.
                if (cyc == 2) t0 = n;
                if (cyc == 3) t1 = n;
            end
            was = dis_act;
        end
        trip_en <= 1'b0;
        chk("cycle_count", full ? 16 : 8, cyc);
        chk("second_half", full ? 8 : 0, hi);
        chk_near("cycle_span", 80, t1 - t0, 2);
        axi_rd(`MCT_DTIME_ADDR, d, r);
        chk_near("dis_time", 4, int'(d[15:0]), 3);
    endtask : t_meas

    // Continuous mode restarts at once; stop ends it in any phase.
    task automatic t_stop();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        trip_en <= 1'b1;
        axi_wr(`MCT_CFG1_ADDR, {8'h00, 12'd20, 12'h001});
        axi_wr(`MCT_CTRL_ADDR, 32'h08);
        axi_wr(`MCT_CMD_ADDR, 32'h1);
        while (!done && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        chk("restart", 1, dis_act);
        axi_wr(`MCT_CMD_ADDR, 32'h2);
        chk("stop_dis", 0, dis_act);
        axi_rd(`MCT_STAT_ADDR, d, r);
        chk("stop_busy", 0, d[1]);
        trip_en <= 1'b0;
    endtask : t_stop

    // Pulsed oscillator: off while idle, warm-up before discharge.
    task automatic t_warm(input logic [1:0] m, input int w);
        int n;
        trip_en <= 1'b1;
        axi_wr(`MCT_CFG1_ADDR, {8'h00, 12'd2, 12'h001});
        axi_wr(`MCT_CTRL_ADDR, {25'h0, 2'b01, m, 3'b100});
        repeat (4) @(posedge mclk);
        chk("osc_idle_off", 0, osc_en);
        axi_wr(`MCT_CMD_ADDR, 32'h1);
        n = 0;
        while (!dis_act && n < 500) begin
            @(posedge mclk);
            n++;
        end
        chk_near("warm_span", w, n, 4);
        chk("osc_measuring", 1, osc_en);
        n = 0;
        while (!done && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        trip_en <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("osc_after_off", 0, osc_en);
    endtask : t_warm

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        {reset_n, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, trip, trip_en, fast_clk, slow_clk} = '0;
        div_cnt = 5'h00;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        for (int k = 0; k < 4; k++) begin
            t_timeout({3'b010, 2'b00, k[1:0]}, 4, 4 << k);
        end
        t_timeout(7'b0101100, 2, 32);
        t_meas(1'b0);
        t_meas(1'b1);
        t_stop();
        t_warm(2'b10, 8);
        t_warm(2'b11, 16);
        test_done();
    end

    // Whole run is about 4300 cycles; this limit is well beyond it.
    initial begin
        #3_000_000;
        num_errors++;
        test_done();
    end
endmodule : tb
